//--- src/kslock_defs.svh
// Constant definitions for the keypad settings lockout block
`ifndef KSLOCK_DEFS_SVH
`define KSLOCK_DEFS_SVH

`define KSL_DEFAULT_CODE 12'h555
`define KSL_BYPASS_CODE 12'h999
`define KSL_DIGIT_ZERO 4'h0
`define KSL_DIGITS 2'h3
`define KSL_MSG_TIME_MS 2
`define KSL_CLK_MHZ 50
`define KSL_MSG_CYCLES (`KSL_MSG_TIME_MS * 1000 * `KSL_CLK_MHZ)

`endif

//--- src/kslock_pkg.sv
// Types shared by the keypad settings lockout block
package kslock_pkg;

    // One keypad event as seen by the lockout logic
    typedef struct packed {
        logic digit;
        logic enter;
        logic esc;
        logic [3:0] value;
    } kslock_key_t;

    // Display screen reported to the front panel
    typedef enum logic [3:0] {
        KSLOCK_SCR_MAIN = 4'h0,
        KSLOCK_SCR_CODE = 4'h1,
        KSLOCK_SCR_TOGGLE = 4'h2,
        KSLOCK_SCR_CHGASK = 4'h3,
        KSLOCK_SCR_CHGCODE = 4'h4,
        KSLOCK_SCR_DONE = 4'h5,
        KSLOCK_SCR_ERROR = 4'h6
    } kslock_screen_t;

    // Settings change requests from the panel
    typedef struct packed {
        logic range;
        logic trigger;
        logic delay;
        logic comm;
        logic line_freq;
        logic cal_menu;
    } kslock_req_t;

endpackage

//--- src/kslock_keysync.sv
// Pin synchroniser and one-shot event former for keypad lines
`timescale 1ns/1ps
`default_nettype none

module kslock_keysync #(
    parameter int WIDTH = 7
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Raw pin levels
    input wire logic [WIDTH-1:0] pin_in,
    // Level and rising edge after filtering
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out
);
    logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r, rise_r;
    logic [WIDTH-1:0] lvl_nxt, rise_nxt;

    // Accept a change once second and third stages agree
    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                lvl_nxt[i] = s3_r[i];
            end
        end
        rise_nxt = lvl_nxt & ~lvl_r;
    end

    // Three-stage chain and filtered state
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
            rise_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign level_out = lvl_r;
    assign rise_out = rise_r;
endmodule

`default_nettype wire

//--- src/kslock_top.sv
// Keypad settings lockout controller
`timescale 1ns/1ps
`default_nettype none
`include "kslock_defs.svh"

module kslock_top #(
    parameter int MSG_CYCLES = `KSL_MSG_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Keypad pins, digit value and key strobes
    input wire logic [3:0] key_value_in,
    input wire logic key_digit_in,
    input wire logic key_enter_in,
    input wire logic key_esc_in,
    // Factory reset of the stored code, calibration jumper
    input wire logic factory_rst_in,
    input wire logic cal_jumper_in,
    // Setting change requests
    input wire kslock_pkg::kslock_req_t req_in,
    // Lock state, grants and display
    output logic locked_out,
    output kslock_pkg::kslock_req_t grant_out,
    output kslock_pkg::kslock_screen_t screen_out,
    output logic [11:0] show_code_out,
    output logic [1:0] digit_count_out
);
    import kslock_pkg::*;

    // One-hot states
    typedef enum logic [7:0] {
        KSL_MAIN = 8'h01,
        KSL_ESC = 8'h02,
        KSL_CODE = 8'h04,
        KSL_TOGGLE = 8'h08,
        KSL_CHGASK = 8'h10,
        KSL_CHGCODE = 8'h20,
        KSL_MSG = 8'h40,
        KSL_CHGESC = 8'h80
    } kslock_state_t;

    logic [7:0] lvl, rise;
    kslock_key_t key;
    kslock_state_t state_r, state_nxt;
    logic [11:0] code_r, code_nxt, entry_r, entry_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic lock_r, lock_nxt, bypass_r, bypass_nxt;
    logic [31:0] tmr_r, tmr_nxt;
    kslock_screen_t scr_r, scr_nxt;
    kslock_req_t grant_r, grant_nxt;
    logic [11:0] show_r, show_nxt;

    // Pin synchroniser for the keypad and factory reset lines
    kslock_keysync #(.WIDTH(8)) u_sync (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .pin_in({factory_rst_in, key_esc_in, key_enter_in, key_digit_in,
                 key_value_in}),
        .level_out(lvl),
        .rise_out(rise)
    );

    // Key event bundle, value filtered alongside the strobes
    always_comb begin
        key.digit = rise[4];
        key.enter = rise[5];
        key.esc = rise[6];
        key.value = lvl[3:0];
    end

    // Append a digit to the entry
    function automatic logic [11:0] push_digit(input logic [11:0] e,
                                               input logic [3:0] d);
        push_digit = {e[7:0], d};
    endfunction

    // Lockout menu sequencing
    always_comb begin
        state_nxt = state_r;
        code_nxt = code_r;
        entry_nxt = entry_r;
        cnt_nxt = cnt_r;
        lock_nxt = lock_r;
        bypass_nxt = bypass_r;
        tmr_nxt = (tmr_r != 32'h0) ? tmr_r - 32'h1 : 32'h0;
        scr_nxt = scr_r;
        show_nxt = show_r;
        case (state_r)
            KSL_MAIN: begin
                scr_nxt = KSLOCK_SCR_MAIN;
                if (key.esc) begin
                    state_nxt = KSL_ESC;
                end
            end
            KSL_ESC: begin
                if (key.digit && key.value == `KSL_DIGIT_ZERO) begin
                    state_nxt = KSL_CODE;
                    entry_nxt = '0;
                    cnt_nxt = '0;
                    scr_nxt = KSLOCK_SCR_CODE;
                end else if (key.digit || key.enter) begin
                    state_nxt = KSL_MAIN;
                end
            end
            KSL_CODE: begin
                if (key.esc && cnt_r != 2'h0) begin
                    entry_nxt = {4'h0, entry_r[11:4]};
                    cnt_nxt = cnt_r - 2'h1;
                end else if (key.digit && cnt_r != `KSL_DIGITS) begin
                    entry_nxt = push_digit(entry_r, key.value);
                    cnt_nxt = cnt_r + 2'h1;
                end else if (key.enter && cnt_r == `KSL_DIGITS) begin
                    if (entry_r == code_r) begin
                        state_nxt = KSL_TOGGLE;
                        bypass_nxt = 1'b0;
                        scr_nxt = KSLOCK_SCR_TOGGLE;
                    end else if (entry_r == `KSL_BYPASS_CODE) begin
                        state_nxt = KSL_TOGGLE;
                        bypass_nxt = 1'b1;
                        scr_nxt = KSLOCK_SCR_TOGGLE;
                    end else begin
                        state_nxt = KSL_MAIN;
                        scr_nxt = KSLOCK_SCR_MAIN;
                    end
                end
            end
            KSL_TOGGLE: begin
                if (key.enter) begin
                    // Bypass can only clear the lock
                    lock_nxt = bypass_r ? 1'b0 : ~lock_r;
                    state_nxt = KSL_MSG;
                    scr_nxt = KSLOCK_SCR_DONE;
                    tmr_nxt = 32'(MSG_CYCLES);
                end else if (key.esc) begin
                    state_nxt = KSL_MSG;
                    scr_nxt = KSLOCK_SCR_ERROR;
                    tmr_nxt = 32'(MSG_CYCLES);
                end else if (key.digit && key.value == `KSL_DIGIT_ZERO
                             && !bypass_r) begin
                    state_nxt = KSL_CHGASK;
                    scr_nxt = KSLOCK_SCR_CHGASK;
                end
            end
            KSL_CHGASK: begin
                if (key.enter) begin
                    state_nxt = KSL_CHGCODE;
                    show_nxt = code_r;
                    entry_nxt = '0;
                    cnt_nxt = '0;
                    scr_nxt = KSLOCK_SCR_CHGCODE;
                end else if (key.esc) begin
                    state_nxt = KSL_MAIN;
                    scr_nxt = KSLOCK_SCR_MAIN;
                end
            end
            KSL_CHGCODE: begin
                if (key.esc && cnt_r != 2'h0) begin
                    entry_nxt = {4'h0, entry_r[11:4]};
                    cnt_nxt = cnt_r - 2'h1;
                    show_nxt = {4'h0, entry_r[11:4]};
                end else if (key.esc) begin
                    state_nxt = KSL_CHGESC;
                end else if (key.digit && cnt_r != `KSL_DIGITS) begin
                    entry_nxt = push_digit(entry_r, key.value);
                    show_nxt = push_digit(entry_r, key.value);
                    cnt_nxt = cnt_r + 2'h1;
                end else if (key.enter && cnt_r == `KSL_DIGITS) begin
                    code_nxt = entry_r;
                    state_nxt = KSL_MAIN;
                    scr_nxt = KSLOCK_SCR_MAIN;
                end
            end
            KSL_CHGESC: begin
                if (key.enter) begin
                    state_nxt = KSL_MAIN;
                    scr_nxt = KSLOCK_SCR_MAIN;
                end else if (key.digit) begin
                    entry_nxt = push_digit(12'h000, key.value);
                    show_nxt = push_digit(12'h000, key.value);
                    cnt_nxt = 2'h1;
                    state_nxt = KSL_CHGCODE;
                end
            end
            KSL_MSG: begin
                if (tmr_r == 32'h1) begin
                    state_nxt = KSL_MAIN;
                    scr_nxt = KSLOCK_SCR_MAIN;
                end
            end
            default: begin
                state_nxt = KSL_MAIN;
                scr_nxt = KSLOCK_SCR_MAIN;
            end
        endcase
        if (rise[7]) begin
            code_nxt = `KSL_DEFAULT_CODE;
        end
    end

    // Grants for protected settings
    always_comb begin
        grant_nxt.range = req_in.range && !lock_r;
        grant_nxt.trigger = req_in.trigger && !lock_r;
        grant_nxt.delay = req_in.delay && !lock_r;
        grant_nxt.comm = req_in.comm && !lock_r;
        grant_nxt.line_freq = req_in.line_freq && !lock_r;
        grant_nxt.cal_menu = req_in.cal_menu && !lock_r
                             && cal_jumper_in;
    end

    // State registers
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= KSL_MAIN;
            code_r <= `KSL_DEFAULT_CODE;
            entry_r <= '0;
            cnt_r <= '0;
            lock_r <= 1'b0;
            bypass_r <= 1'b0;
            tmr_r <= '0;
            scr_r <= KSLOCK_SCR_MAIN;
            grant_r <= '0;
            show_r <= '0;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            entry_r <= entry_nxt;
            cnt_r <= cnt_nxt;
            lock_r <= lock_nxt;
            bypass_r <= bypass_nxt;
            tmr_r <= tmr_nxt;
            scr_r <= scr_nxt;
            grant_r <= grant_nxt;
            show_r <= show_nxt;
        end
    end

    assign locked_out = lock_r;
    assign grant_out = grant_r;
    assign screen_out = scr_r;
    assign show_code_out = show_r;
    assign digit_count_out = cnt_r;
endmodule

`default_nettype wire

//--- verification/kslock_keypad_model.sv
// Keypad operator model pressing digit, enter and escape keys
`timescale 1ns/1ps
`default_nettype none

module kslock_keypad_model (
    // Clock
    input wire logic clk_sys_in,
    // Key pins
    output logic [3:0] key_value_out,
    output logic key_digit_out,
    output logic key_enter_out,
    output logic key_esc_out
);
    // All keys released, value line holds no digit
    initial begin
        key_value_out = 4'hA;
        {key_digit_out, key_enter_out, key_esc_out} = 3'h0;
    end

    // One press: kind 0 digit, 1 enter, 2 escape, then a release gap
    task automatic press(input logic [1:0] kind, input logic [3:0] val);
        @(negedge clk_sys_in);
        key_value_out = val;
        {key_digit_out, key_enter_out, key_esc_out} = 3'h4 >> kind;
        repeat (6) @(negedge clk_sys_in);
        {key_digit_out, key_enter_out, key_esc_out} = 3'h0;
        key_value_out = ~val; // No stale digit after release
        repeat (8) @(negedge clk_sys_in);
    endtask
endmodule

`default_nettype wire

//--- verification/kslock_monitor.sv
// Assertion checker for the keypad settings lockout block
`timescale 1ns/1ps
`default_nettype none

module kslock_monitor #(
    parameter int MSG_CYCLES = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    // Watched ports
    input wire logic cal_jumper_in,
    input wire kslock_pkg::kslock_req_t req_in,
    input wire logic locked_out,
    input wire kslock_pkg::kslock_req_t grant_out,
    input wire kslock_pkg::kslock_screen_t screen_out,
    input wire logic [1:0] digit_count_out
);
    import kslock_pkg::*;
    logic in_msg;
    logic [31:0] msg_cnt_r;
    logic [31:0] msg_cnt_nxt;

    // Cycles spent on a message screen
    assign in_msg = screen_out inside {KSLOCK_SCR_DONE, KSLOCK_SCR_ERROR};
    always_comb begin
        msg_cnt_nxt = in_msg ? msg_cnt_r + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            msg_cnt_r <= 32'h0;
        end else begin
            msg_cnt_r <= msg_cnt_nxt;
        end
    end

    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);

    // Lock and screen relations
    a_grant_when_free: assert property (
        grant_out[5:1] == ($past(req_in[5:1]) & {5{!$past(locked_out)}}))
        else $error("setting grant disagrees with lock");
    a_cal_needs_jumper: assert property (
        grant_out.cal_menu ==
        $past(req_in.cal_menu && !locked_out && cal_jumper_in))
        else $error("calibration grant wrong");
    a_lock_on_enter: assert property ($changed(locked_out) |->
        screen_out == KSLOCK_SCR_DONE &&
        $past(screen_out) == KSLOCK_SCR_TOGGLE)
        else $error("lock changed outside toggle prompt");
    a_error_keeps_lock: assert property (
        $rose(screen_out == KSLOCK_SCR_ERROR) |->
        $past(screen_out) == KSLOCK_SCR_TOGGLE && $stable(locked_out))
        else $error("error screen path wrong");
    a_prompt_from_main: assert property (
        $rose(screen_out == KSLOCK_SCR_CODE) |->
        $past(screen_out) == KSLOCK_SCR_MAIN)
        else $error("code prompt not from main");
    a_toggle_three_digits: assert property (
        $rose(screen_out == KSLOCK_SCR_TOGGLE) |->
        $past(screen_out) == KSLOCK_SCR_CODE && $past(digit_count_out) == 2'h3)
        else $error("toggle prompt without three digits");
    a_change_via_ask: assert property (
        $rose(screen_out == KSLOCK_SCR_CHGCODE) |->
        $past(screen_out) == KSLOCK_SCR_CHGASK)
        else $error("change screen not from change prompt");
    a_msg_length: assert property ($fell(in_msg) |->
        screen_out == KSLOCK_SCR_MAIN && msg_cnt_r >= MSG_CYCLES &&
        msg_cnt_r <= MSG_CYCLES + 1)
        else $error("message time or exit screen wrong");

    // Main scenarios
    c_lock_set: cover property ($rose(locked_out));
    c_lock_clear: cover property ($fell(locked_out));
    c_error_seen: cover property ($rose(screen_out == KSLOCK_SCR_ERROR));
endmodule

bind kslock_top kslock_monitor #(.MSG_CYCLES(MSG_CYCLES)) u_mon (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .cal_jumper_in(cal_jumper_in), .req_in(req_in),
    .locked_out(locked_out), .grant_out(grant_out),
    .screen_out(screen_out), .digit_count_out(digit_count_out));

`default_nettype wire

//--- verification/keypad_settings_lockout_tb_top.sv
// Self-checking testbench for the keypad settings lockout block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module keypad_settings_lockout_tb_top;
    import kslock_pkg::*;
    logic clk_sys_in, nrst_in, factory_rst_in, cal_jumper_in, chk_en;
    logic key_digit, key_enter, key_esc, locked_out, lock_q, jmp_q;
    logic [3:0] key_value;
    logic [11:0] show_code_out, nc;
    logic [1:0] digit_count_out;
    logic [2:0] rd;
    logic [7:0] lfsr;
    logic [15:0] seen;
    kslock_req_t req_in, req_q, grant_out;
    kslock_screen_t screen_out;
    int checks, miscompares;

    kslock_keypad_model u_kp (.clk_sys_in(clk_sys_in),
        .key_value_out(key_value), .key_digit_out(key_digit),
        .key_enter_out(key_enter), .key_esc_out(key_esc));
    kslock_top #(.MSG_CYCLES(4)) uut (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .key_value_in(key_value), .key_digit_in(key_digit),
        .key_enter_in(key_enter), .key_esc_in(key_esc),
        .factory_rst_in(factory_rst_in), .cal_jumper_in(cal_jumper_in),
        .req_in(req_in), .locked_out(locked_out), .grant_out(grant_out),
        .screen_out(screen_out), .show_code_out(show_code_out),
        .digit_count_out(digit_count_out));

    // 50 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end

    // Expected grants from last cycle's requests, lock and jumper
    function automatic kslock_req_t exp_grant(input kslock_req_t r,
                                              input logic lk, input logic jp);
        exp_grant = kslock_req_t'(r & {6{!lk}});
        exp_grant.cal_menu = r.cal_menu & !lk & jp;
    endfunction

    // Sample what the grant register saw
    always @(posedge clk_sys_in) begin
        req_q <= req_in;
        lock_q <= locked_out;
        jmp_q <= cal_jumper_in;
    end

    // Grant check, screen history and random requests
    always @(negedge clk_sys_in) begin
        seen[screen_out] <= 1'b1;
        if (chk_en) begin
            `CHK(grant_out, exp_grant(req_q, lock_q, jmp_q))
            lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            req_in <= kslock_req_t'(lfsr[5:0]);
            cal_jumper_in <= lfsr[7];
        end
    end

    // Keys from text: X escape, E enter, else a digit
    task automatic keys(input string s);
        for (int i = 0; i < s.len(); i++) begin
            u_kp.press(s[i] == "E" ? 2'h1 : s[i] == "X" ? 2'h2 : 2'h0,
                       4'(s[i] - 8'h30));
        end
    endtask

    // Counts and verdict
    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        nrst_in = 1'b0;
        factory_rst_in = 1'b0;
        cal_jumper_in = 1'b0;
        req_in = '0;
        chk_en = 1'b0;
        lfsr = 8'h44;
        seen = '0;
        checks = 0;
        miscompares = 0;
        repeat (12) @(negedge clk_sys_in);
        nrst_in = 1'b1;
        `CHK({locked_out, screen_out, digit_count_out}, 7'h0)
        chk_en = 1'b1;
        keys("X0");
        `CHK(screen_out, KSLOCK_SCR_CODE)
        keys("12X");
        `CHK(digit_count_out, 2'h1)
        keys("EX5555");
        `CHK({screen_out, digit_count_out}, {KSLOCK_SCR_CODE, 2'h3})
        keys("E");
        `CHK(screen_out, KSLOCK_SCR_TOGGLE)
        seen = '0;
        keys("E");
        `CHK({locked_out, seen[KSLOCK_SCR_DONE]}, 2'h3)
        // Wrong codes leave everything alone
        repeat (3) begin
            keys($sformatf("X02%0d%0dE", lfsr[2:0], lfsr[6:4]));
            `CHK({locked_out, screen_out}, {1'b1, KSLOCK_SCR_MAIN})
        end
        keys("X0555E");
        seen = '0;
        keys("X");
        `CHK({locked_out, seen[KSLOCK_SCR_ERROR]}, 2'h3)
        // Bypass only clears, never offers a change
        keys("X0999E0");
        `CHK(screen_out, KSLOCK_SCR_TOGGLE)
        keys("E");
        `CHK(locked_out, 1'b0)
        keys("X0999EE");
        `CHK(locked_out, 1'b0)
        // Escape at the change offer goes back to main
        keys("X0555E0X");
        `CHK({locked_out, screen_out}, {1'b0, KSLOCK_SCR_MAIN})
        // Store a new code, old one then refused
        rd = lfsr[2:0];
        nc = {4'h1, 1'b0, rd, 4'h7};
        keys("X0555E0");
        `CHK(screen_out, KSLOCK_SCR_CHGASK)
        keys("E");
        `CHK(screen_out, KSLOCK_SCR_CHGCODE)
        `CHK(show_code_out, 12'h555)
        keys($sformatf("19X%0d7", rd));
        `CHK(show_code_out, nc)
        keys("EX0555E");
        `CHK(screen_out, KSLOCK_SCR_MAIN)
        // Leaving the change screen keeps the code
        keys($sformatf("X01%0d7E0EXE", rd));
        keys($sformatf("X01%0d7E", rd));
        `CHK(screen_out, KSLOCK_SCR_TOGGLE)
        keys("X");
        // Factory restore brings the default code back
        factory_rst_in = 1'b1;
        repeat (8) @(negedge clk_sys_in);
        factory_rst_in = 1'b0;
        keys("X0555E");
        `CHK(screen_out, KSLOCK_SCR_TOGGLE)
        keys("E");
        `CHK(locked_out, 1'b1)
        repeat (20) @(negedge clk_sys_in);
        wrap_up();
    end
endmodule

`default_nettype wire
